// File: core/uar_regs.svh
// register map, field positions, reset values and sampling counts of the receiver
// assumes a 32-bit AXI4-Lite slave with byte addresses
`ifndef UAR_REGS_SVH
`define UAR_REGS_SVH
`define UAR_ADDR_W      8
`define UAR_DATA_OFF    8'h00
`define UAR_STAT_OFF    8'h04
`define UAR_CTRL_OFF    8'h08
`define UAR_BAUD_OFF    8'h0c
`define UAR_STAT_RXC    7
`define UAR_STAT_FE     4
`define UAR_STAT_PE     2
`define UAR_STAT_DS     1
`define UAR_CTRL_EN     0
`define UAR_CTRL_PCE    1
`define UAR_CTRL_ODD    2
`define UAR_CTRL_DS     3
`define UAR_CTRL_CSZ    4
`define UAR_CSZ_RST     2'h3
`define UAR_DIV_W       12
`define UAR_DIV_RST     16'h0043
`define UAR_SPB_NORM    5'h10
`define UAR_SPB_DBL     5'h08
`define UAR_SF_NORM     5'h08
`define UAR_SF_DBL      5'h04
`define UAR_MIN_DATA    4'h5
`define UAR_RESP_OKAY   2'h0
`define UAR_RESP_SLVERR 2'h2
`endif

// File: core/uar_pkg.sv
// types shared by the receiver
// assumes nothing beyond the register header
package uar_pkg;
    typedef enum logic [1:0] {
        UAR_IDLE,
        UAR_START,
        UAR_BITS
    } uar_rx_state_type;

    typedef struct packed {
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } uar_entry_type;
endpackage : uar_pkg

// File: core/uar_receiver.sv
// asynchronous serial receiver with two-entry buffer and AXI4-Lite registers
// assumes serial_in_pin is asynchronous; clock at 125 MHz; bus on the same clock
//
// Function
// - parity is compared only while parity_check_enable is set
// - parity_odd_select chooses odd or even expected parity
// - parity outcome is stored with its character and stop bit in the buffer
// - parity_error_flag shows the head character until the data register read
// - clearing receiver_enable aborts any frame in progress at once
// - while disabled the pin takeover output is released
// - disabling empties the buffer with all stored status
// - line sampled at 16x baud, or 8x with double_speed_select
// - falling edge from idle starts detection; first low sample is sample one
// - start validity from samples 8,9,10 or 4,5,6 in double speed
// - two or more high check samples reject the start as noise
// - sampling phase realigns on every accepted start bit
// - per-bit sample counter of 16 or 8 states numbers each sample
// - each bit is the two-of-three vote of its centre samples
// - recover data, optional parity, first stop; later stop bits ignored
// - a zero first stop bit marks frame_error_flag for that character
// - a new start edge is seen right after the stop bit vote
// - eight-bit normal frames tolerate 95.36 to 104.58 percent rate
// - rx_complete_flag high exactly while the buffer holds a character
// - buffer is a two-entry fifo advanced by each data register read
`timescale 1ns/100ps
`default_nettype none
`include "uar_regs.svh"

module uar_receiver #(
    parameter int DIV_W = `UAR_DIV_W
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   serial_in_pin,
    output logic                        rx_pin_override,
    output logic                        rx_complete_flag,
    input  wire logic [`UAR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`UAR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    import uar_pkg::*;

    generate
        if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
            $error("DIV_W must be 1 to 16");
        end
    endgenerate

    typedef struct packed {
        logic                     sync1;
        logic                     sync2;
        logic                     line;
        logic [DIV_W-1:0]         div_cnt;
        uar_rx_state_type         st;
        logic [4:0]               scnt;
        logic [3:0]               bidx;
        logic [2:0]               votes;
        logic [7:0]               shreg;
        logic                     par_bit;
        uar_entry_type [1:0]      fifo;
        logic                     head;
        logic [1:0]               cnt;
        logic                     en;
        logic                     pce;
        logic                     odd;
        logic                     ds;
        logic [1:0]               csz;
        logic [DIV_W-1:0]         div;
        logic                     aw_got;
        logic                     w_got;
        logic [`UAR_ADDR_W-1:0]   awaddr;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
    } uar_state_type;

    uar_state_type    q;
    uar_state_type    d;
    logic             tick;
    logic [4:0]       spb;
    logic [4:0]       sf;
    logic [3:0]       nd;
    logic [3:0]       last;
    logic [2:0]       vote_now;
    logic             bitv;
    logic             push;
    logic             pop;
    logic             push_fe;
    logic             push_pe;
    logic             aw_hs;
    logic             w_hs;
    logic             ar_hs;
    logic [`UAR_ADDR_W-1:0] wa;
    logic [31:0]      wd;
    logic [3:0]       ws;

    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3

    // word decode shared by the write and read paths
    function automatic logic hit(input logic [`UAR_ADDR_W-1:0] a,
                                 input logic [`UAR_ADDR_W-1:0] off);
        hit = (a[`UAR_ADDR_W-1:2] == off[`UAR_ADDR_W-1:2]);
    endfunction : hit

    assign s_axi_awready    = !q.aw_got && !q.bvalid;
    assign s_axi_wready     = !q.w_got && !q.bvalid;
    assign s_axi_arready    = !q.rvalid;
    assign s_axi_bvalid     = q.bvalid;
    assign s_axi_bresp      = q.bresp;
    assign s_axi_rvalid     = q.rvalid;
    assign s_axi_rdata      = q.rdata;
    assign s_axi_rresp      = q.rresp;
    assign rx_pin_override  = q.en;
    assign rx_complete_flag = (q.cnt != 2'h0);

    always_comb begin
        d        = q;
        tick     = (q.div_cnt == '0);
        spb      = q.ds ? `UAR_SPB_DBL : `UAR_SPB_NORM;
        sf       = q.ds ? `UAR_SF_DBL : `UAR_SF_NORM;
        nd       = `UAR_MIN_DATA + {2'h0, q.csz};
        last     = nd + {3'h0, q.pce};
        vote_now = {q.votes[1:0], q.sync2};
        bitv     = maj3(vote_now);
        push     = 1'b0;
        push_fe  = !bitv;
        // parity over all data bits; unused upper bits are zero
        push_pe  = q.pce & (^q.shreg ^ q.par_bit ^ q.odd);
        aw_hs    = s_axi_awvalid && s_axi_awready;
        w_hs     = s_axi_wvalid && s_axi_wready;
        ar_hs    = s_axi_arvalid && s_axi_arready;
        pop      = ar_hs && hit(s_axi_araddr, `UAR_DATA_OFF) && (q.cnt != 2'h0);
        wa       = aw_hs ? s_axi_awaddr : q.awaddr;
        wd       = w_hs ? s_axi_wdata : q.wdata;
        ws       = w_hs ? s_axi_wstrb : q.wstrb;

        d.sync1 = serial_in_pin;
        d.sync2 = q.sync1;
        // a new divisor loads only at the next reload, so a large old one delays it
        d.div_cnt = tick ? q.div : q.div_cnt - 1'b1;
        if (tick) begin
            d.line = q.sync2;
        end
        // the sample clock keeps running while idle, so the start edge is
        // known to within one sample, which bounds the tolerated rate error
        if (tick && q.st != UAR_IDLE && q.scnt >= sf && q.scnt <= sf + 5'h2) begin
            d.votes = vote_now;
        end

        unique case (q.st)
            UAR_IDLE: begin
                if (tick && q.en && q.line && !q.sync2) begin
                    d.st    = UAR_START;
                    // this tick took sample one, so the next tick takes sample two
                    d.scnt  = 5'h2;
                    d.shreg = 8'h00;
                end
            end
            UAR_START: begin
                if (tick) begin
                    if (q.scnt == sf + 5'h2 && bitv) begin
                        d.st = UAR_IDLE;
                    end else if (q.scnt == spb) begin
                        d.st   = UAR_BITS;
                        d.scnt = 5'h1;
                        d.bidx = 4'h0;
                    end else begin
                        d.scnt = q.scnt + 5'h1;
                    end
                end
            end
            UAR_BITS: begin
                if (tick) begin
                    if (q.scnt == sf + 5'h2 && q.bidx == last) begin
                        // stop is the last bit used; any second stop is ignored
                        push = 1'b1;
                        d.st = UAR_IDLE;
                    end else begin
                        if (q.scnt == sf + 5'h2) begin
                            if (q.bidx < nd) begin
                                d.shreg[q.bidx[2:0]] = bitv;
                            end else begin
                                d.par_bit = bitv;
                            end
                        end
                        if (q.scnt == spb) begin
                            d.scnt = 5'h1;
                            d.bidx = q.bidx + 4'h1;
                        end else begin
                            d.scnt = q.scnt + 5'h1;
                        end
                    end
                end
            end
        endcase

        // a character arriving with the buffer full and no read is dropped
        if (push && (q.cnt != 2'h2 || pop)) begin
            d.fifo[q.head ^ q.cnt[0]] = '{fe: push_fe, pe: push_pe, data: q.shreg};
        end else begin
            push = 1'b0;
        end
        d.cnt  = q.cnt + {1'b0, push} - {1'b0, pop};
        d.head = q.head ^ pop;

        if (!q.en) begin
            d.st   = UAR_IDLE;
            d.cnt  = 2'h0;
            d.head = 1'b0;
        end

        if (aw_hs) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if ((q.aw_got || aw_hs) && (q.w_got || w_hs)) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `UAR_RESP_OKAY;
            if (hit(wa, `UAR_CTRL_OFF)) begin
                if (ws[0]) begin
                    d.en  = wd[`UAR_CTRL_EN];
                    d.pce = wd[`UAR_CTRL_PCE];
                    d.odd = wd[`UAR_CTRL_ODD];
                    d.ds  = wd[`UAR_CTRL_DS];
                    d.csz = wd[`UAR_CTRL_CSZ+1:`UAR_CTRL_CSZ];
                end
            end else if (hit(wa, `UAR_BAUD_OFF)) begin
                for (int i = 0; i < DIV_W; i++) begin
                    if (ws[i/8]) begin
                        d.div[i] = wd[i];
                    end
                end
            end else if (!hit(wa, `UAR_DATA_OFF) && !hit(wa, `UAR_STAT_OFF)) begin
                d.bresp = `UAR_RESP_SLVERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rresp  = `UAR_RESP_OKAY;
            d.rdata  = 32'h0000_0000;
            if (hit(s_axi_araddr, `UAR_DATA_OFF)) begin
                if (q.cnt != 2'h0) begin
                    d.rdata[7:0] = q.fifo[q.head].data;
                end
            end else if (hit(s_axi_araddr, `UAR_STAT_OFF)) begin
                // status describes the head character until it is read
                d.rdata[`UAR_STAT_RXC] = (q.cnt != 2'h0);
                d.rdata[`UAR_STAT_FE]  = (q.cnt != 2'h0) && q.fifo[q.head].fe;
                d.rdata[`UAR_STAT_PE]  = (q.cnt != 2'h0) && q.fifo[q.head].pe;
                d.rdata[`UAR_STAT_DS]  = q.ds;
            end else if (hit(s_axi_araddr, `UAR_CTRL_OFF)) begin
                d.rdata[`UAR_CTRL_EN]  = q.en;
                d.rdata[`UAR_CTRL_PCE] = q.pce;
                d.rdata[`UAR_CTRL_ODD] = q.odd;
                d.rdata[`UAR_CTRL_DS]  = q.ds;
                d.rdata[`UAR_CTRL_CSZ+1:`UAR_CTRL_CSZ] = q.csz;
            end else if (hit(s_axi_araddr, `UAR_BAUD_OFF)) begin
                d.rdata[DIV_W-1:0] = q.div;
            end else begin
                d.rresp = `UAR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q       <= '0;
            q.sync1 <= 1'b1;
            q.sync2 <= 1'b1;
            q.line  <= 1'b1;
            q.csz   <= `UAR_CSZ_RST;
            q.div   <= DIV_W'(`UAR_DIV_RST);
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    parity_off_clean_a: assert property (push && !q.pce |-> !push_pe)
        else $error("parity error stored while checking disabled");
    disable_flush_a: assert property ($fell(q.en) |=> q.st == UAR_IDLE && q.cnt == 2'h0)
        else $error("disable did not abort and flush");
    disabled_quiet_a: assert property (!q.en |=> !push)
        else $error("character stored while disabled");
    start_reject_a: assert property (q.st == UAR_START && tick && q.scnt == sf + 5'h2
        && bitv |=> q.st == UAR_IDLE)
        else $error("noisy start not rejected");
    start_keep_a: assert property (q.en && q.st == UAR_START && tick
        && q.scnt == sf + 5'h2 && !bitv |=> q.st == UAR_START && q.scnt == sf + 5'h3)
        else $error("valid start lost");
    stop_index_a: assert property (push |-> q.bidx == last && q.scnt == sf + 5'h2)
        else $error("character stored at wrong bit");
    early_edge_a: assert property (push |=> q.st == UAR_IDLE)
        else $error("receiver not idle after stop vote");
    sample_range_a: assert property (q.st != UAR_IDLE |-> q.scnt >= 5'h1 && q.scnt <= spb)
        else $error("sample counter out of range");
    fifo_depth_a: assert property (q.cnt <= 2'h2)
        else $error("buffer count above two");
    fifo_pop_a: assert property (pop && q.en |=> q.cnt == $past(q.cnt) - 2'h1
        + {1'b0, $past(push)})
        else $error("buffer count wrong after read");
    read_hold_a: assert property (q.rvalid && !s_axi_rready |=> q.rvalid && $stable(q.rdata))
        else $error("read data not held");
    start_count_a: assert property (q.st == UAR_IDLE && tick && q.en && q.line
        && !q.sync2 |=> q.st == UAR_START && q.scnt == 5'h2)
        else $error("start edge not counted as sample one");
    store_head_a: assert property (push && q.cnt == 2'h0 && q.en
        |=> q.fifo[q.head].data == $past(q.shreg) && q.fifo[q.head].pe == $past(push_pe))
        else $error("character or status not stored at head");
    divider_reload_a: assert property (tick |=> q.div_cnt == $past(q.div))
        else $error("sample divider not reloaded");
    disabled_idle_a: assert property (!q.en ##1 !q.en
        |-> q.st == UAR_IDLE && !rx_complete_flag)
        else $error("receiver active while disabled");
    stat_empty_a: assert property (ar_hs && hit(s_axi_araddr, `UAR_STAT_OFF)
        && q.cnt == 2'h0 |=> !q.rdata[`UAR_STAT_PE] && !q.rdata[`UAR_STAT_FE])
        else $error("error status shown with empty buffer");

    // accesses are answered, and write answers stand until the master takes them
    write_hold_a: assert property (q.bvalid && !s_axi_bready |=> q.bvalid && $stable(q.bresp))
        else $error("write response not held");
    write_answer_a: assert property ((q.aw_got || aw_hs) && (q.w_got || w_hs) |=> q.bvalid)
        else $error("write not answered");
    read_answer_a: assert property (ar_hs |=> q.rvalid)
        else $error("read not answered");

    // main scenarios the bench is expected to reach
    frame_ok_c: cover property (push && !push_fe && !push_pe);
    double_speed_c: cover property (push && q.ds && !push_fe);
    frame_err_c: cover property (push && push_fe);
    parity_err_c: cover property (push && push_pe);
    noise_start_c: cover property (q.st == UAR_START ##1 q.st == UAR_IDLE);
endmodule : uar_receiver
`default_nettype wire

// File: tb/uar_tx_model.sv
// behavioural remote transmitter that drives the receiver's serial line
// assumes bit and stop lengths are given in system clocks; the line idles high
`timescale 1ns/100ps
`default_nettype none
module uar_tx_model (
    input  wire logic clock,
    output var logic  line
);
    initial line = 1'b1;

    // start, nb data bits lsb first, optional parity, one stop of slen clocks
    task automatic send(input logic [7:0] d, input int nb, input bit pen, input bit par,
                        input bit stop, input int bclk, input int slen);
        @(posedge clock) line <= 1'b0;
        repeat (bclk) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            line <= d[i];
            repeat (bclk) @(posedge clock);
        end
        if (pen) begin
            line <= par;
            repeat (bclk) @(posedge clock);
        end
        line <= stop;
        repeat (slen) @(posedge clock);
        line <= 1'b1;
    endtask : send

    // short low pulse, too brief to pass the start-bit vote
    task automatic glitch(input int n);
        @(posedge clock) line <= 1'b0;
        repeat (n) @(posedge clock);
        line <= 1'b1;
    endtask : glitch
endmodule : uar_tx_model
`default_nettype wire

// File: tb/tb_uar_receiver.sv
// self-checking bench: register accesses over AXI4-Lite and frames from a model transmitter
// assumes baud divisor 1, so one sample every 2 clocks and 32 clocks per normal bit
`timescale 1ns/100ps
`default_nettype none
`include "uar_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_uar_receiver;
    import uar_pkg::*;
    logic        clock, rst_b, serial_in_pin, rx_pin_override, rx_complete_flag;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          error_cnt = 0, tests_run = 0, cyc = 0, n;
    logic [7:0]  d;
    bit          p;

    uar_receiver #(.DIV_W(12)) uar_receiver_i (.clock(clock), .rst_b(rst_b),
        .serial_in_pin(serial_in_pin), .rx_pin_override(rx_pin_override),
        .rx_complete_flag(rx_complete_flag), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    uar_tx_model uar_tx_model_i (.clock(clock), .line(serial_in_pin));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // ready and valid are looked at mid-cycle, so the handshake edge is the next rising one
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        bit ar, wr, b;
        @(posedge clock);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(negedge clock);
            ar = s_axi_awready; wr = s_axi_wready; b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clock);
            if (ar) s_axi_awvalid <= 1'b0;
            if (wr) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
        bit ar, r;
        @(posedge clock);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(negedge clock);
            ar = s_axi_arready; r = s_axi_rvalid; v = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clock);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (!r);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    // status is read before data, as the buffered flags follow the head entry
    task automatic chk_rx(input logic [31:0] st, input logic [7:0] dv);
        axi_rd(`UAR_STAT_OFF, rd);
        `CHK(rd, st)
        axi_rd(`UAR_DATA_OFF, rd);
        `CHK(rd, {24'h0, dv})
    endtask : chk_rx

    initial begin
        forever begin
            @(posedge clock);
            cyc++;
            if (cyc >= 40000) begin
                error_cnt++;
                tally_and_finish();
            end
        end
    end

    initial begin
        rst_b = 1'b0; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        `CHK(rx_pin_override, 1'b0)
        axi_rd(`UAR_CTRL_OFF, rd);
        `CHK(rd, 32'h0000_0030)
        `CHK(rsp, `UAR_RESP_OKAY)
        axi_rd(`UAR_BAUD_OFF, rd);
        `CHK(rd, 32'h0000_0043)
        axi_rd(8'h10, rd);
        `CHK(rd, 32'h0)
        `CHK(rsp, `UAR_RESP_SLVERR)
        axi_wr(8'h10, 32'hff);
        `CHK(rsp, `UAR_RESP_SLVERR)
        axi_wr(`UAR_BAUD_OFF, 32'h1);
        `CHK(rsp, `UAR_RESP_OKAY)
        // the reset divisor must run out before the new one loads
        repeat (80) @(posedge clock);
        axi_wr(`UAR_CTRL_OFF, 32'h31);
        `CHK(rx_pin_override, 1'b1)
        uar_tx_model_i.send(8'ha5, 8, 0, 0, 1, 32, 32);
        chk_rx(32'h80, 8'ha5);
        `CHK(rx_complete_flag, 1'b0)
        $display("basic frame done");
        // short first stop lets the next start follow the stop vote closely
        uar_tx_model_i.send(8'h3c, 8, 0, 0, 1, 32, 24);
        uar_tx_model_i.send(8'hc3, 8, 0, 0, 0, 32, 32);
        chk_rx(32'h80, 8'h3c);
        chk_rx(32'h90, 8'hc3);
        for (int b = 31; b <= 33; b += 2) begin
            uar_tx_model_i.send(8'h5a, 8, 0, 0, 1, b, b);
            chk_rx(32'h80, 8'h5a);
        end
        $display("sequence and rate done");
        for (int i = 0; i < 4; i++) begin
            d = 8'h35 + i[7:0];
            p = ^d ^ i[1] ^ i[0];
            axi_wr(`UAR_CTRL_OFF, 32'h33 | (i[1] << 2));
            uar_tx_model_i.send(d, 8, 1, p, 1, 32, 32);
            chk_rx(32'h80 | (i[0] << 2), d);
        end
        $display("parity done");
        axi_wr(`UAR_CTRL_OFF, 32'h31);
        uar_tx_model_i.glitch(8);
        // long enough for a wrongly accepted all-ones frame to land
        repeat (400) @(posedge clock);
        `CHK(rx_complete_flag, 1'b0)
        axi_wr(`UAR_CTRL_OFF, 32'h39);
        uar_tx_model_i.send(8'he7, 8, 0, 0, 1, 16, 16);
        chk_rx(32'h82, 8'he7);
        axi_wr(`UAR_CTRL_OFF, 32'h01);
        uar_tx_model_i.send(8'h15, 5, 0, 0, 1, 32, 64);
        chk_rx(32'h80, 8'h15);
        $display("noise speed size done");
        axi_wr(`UAR_CTRL_OFF, 32'h31);
        uar_tx_model_i.send(8'h11, 8, 0, 0, 1, 32, 32);
        uar_tx_model_i.send(8'h22, 8, 0, 0, 1, 32, 32);
        n = 0;
        while (rx_complete_flag === 1'b1 && n < 4) begin
            axi_rd(`UAR_DATA_OFF, rd);
            n++;
        end
        `CHK(n, 2)
        uar_tx_model_i.send(8'h44, 8, 0, 0, 1, 32, 32);
        uar_tx_model_i.send(8'h55, 8, 0, 0, 1, 32, 32);
        axi_wr(`UAR_CTRL_OFF, 32'h30);
        @(posedge clock);
        `CHK(rx_complete_flag, 1'b0)
        `CHK(rx_pin_override, 1'b0)
        axi_wr(`UAR_CTRL_OFF, 32'h31);
        axi_rd(`UAR_STAT_OFF, rd);
        `CHK(rd, 32'h0)
        fork
            uar_tx_model_i.send(8'hff, 8, 0, 0, 1, 32, 32);
            begin
                repeat (100) @(posedge clock);
                axi_wr(`UAR_CTRL_OFF, 32'h30);
                axi_wr(`UAR_CTRL_OFF, 32'h31);
            end
        join
        repeat (40) @(posedge clock);
        axi_rd(`UAR_STAT_OFF, rd);
        `CHK(rd, 32'h0)
        $display("flush and disable done");
        tally_and_finish();
    end
endmodule : tb_uar_receiver
`default_nettype wire
